/* hw/rpc_pkg.sv */
// rpc_pkg: register map, field positions and timing constants for the rtc periodic/correction block
// assumes a 32-bit avalon-mm slave with word addressing expressed as byte offsets
package rpc_pkg;
  // register byte offsets (word aligned)
  localparam logic [7:0] OFF_CTRL       = 8'h00; // prescale select, tamper-clears, storage enables
  localparam logic [7:0] OFF_EVENT_CTRL = 8'h04; // periodic event output enables
  localparam logic [7:0] OFF_FREQ_CORR  = 8'h08; // sign + magnitude
  localparam logic [7:0] OFF_FLAGS      = 8'h0c; // calendar interrupt flags, w1c
  localparam logic [7:0] OFF_IEN_CLR    = 8'h10;
  localparam logic [7:0] OFF_IEN_SET    = 8'h14;
  localparam logic [7:0] OFF_PRESC      = 8'h18; // prescaler value, read only
  localparam logic [7:0] OFF_STORAGE    = 8'h20; // storage 0..3 at 0x20..0x2c
  localparam logic [7:0] OFF_STATUS     = 8'h30; // irq and correction status, read only
  // control register fields
  localparam int CTRL_PSEL_LSB    = 0;  // 4-bit counter prescale select
  localparam int CTRL_PSEL_W      = 4;
  localparam int CTRL_TAMPER_CLR  = 4;  // tamper clears storage
  localparam int CTRL_PAIR_EN_LSB = 8;  // two storage pair enables
  // frequency correction fields
  localparam int FC_VAL_W = 7;
  localparam int FC_SIGN  = 7;
  // flag positions
  localparam int FLG_OVERFLOW = 15;
  localparam int FLG_TAMPER   = 14;
  localparam int FLG_ALARM    = 8;
  localparam logic [15:0] FLAG_MASK  = 16'hc1ff;
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  // prescaler and correction timing
  localparam int PRESC_W        = 10;
  localparam int PER_LSB        = 2;   // periodic taps are prescaler bits 2..9
  localparam int CORR_PERIOD    = 8192;
  localparam int CORR_CNT_W     = 13;
  localparam int CORR_FRAMES    = 128;
  localparam int FRAME_W        = 7;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

/* hw/rpc_corr.sv */
// rpc_corr: correction scheduler spreading magnitude adjustments over 128 periods
// assumes tick marks each prescaler source clock; runs in the sys_clk domain
`timescale 1ns/1ps
module rpc_corr
  import rpc_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  // control
  input  wire logic                tick,
  input  wire logic                active,
  input  wire logic [FC_VAL_W-1:0] magnitude,
  // result
  output logic                     apply
);
  logic [CORR_CNT_W-1:0] period_cnt;
  logic [FRAME_W-1:0]    frame;
  logic [FRAME_W:0]      acc;
  logic [FRAME_W:0]      next_acc;
  logic                  period_end;

  assign period_end = tick && (period_cnt == CORR_CNT_W'(CORR_PERIOD - 1));
  // bresenham spread: adjust in exactly magnitude of every 128 periods
  assign next_acc   = acc + {1'b0, magnitude};
  assign apply      = period_end && active && next_acc[FRAME_W];

  // period counter and accumulator; at most one adjustment per period
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt <= '0;
      frame      <= '0;
      acc        <= '0;
    end else if (clk_en && tick) begin
      period_cnt <= period_cnt + 1'b1;
      if (period_end) begin
        frame <= frame + 1'b1;
        // restart the sequence each 128 frames so the count is exact per window
        acc   <= (frame == FRAME_W'(CORR_FRAMES - 1)) ? '0 : {1'b0, next_acc[FRAME_W-1:0]};
      end
    end
  end
endmodule // rpc_corr

/* hw/rpc_top.sv */
// rpc_top: rtc prescaler periodic events, frequency correction, storage and calendar flags
// assumes osc_tick is a one-cycle sys_clk pulse per prescaler source clock, cnt_tick per counter clock
//
// What this block does
// - enabled periodic output n pulses on rising edge of prescaler tap n+2, taps 2..9
// - periodic output n fires every 2^(n+3) source clock cycles
// - periodic events ignore prescale select, except none when select is zero
// - frequency correction only when prescale select exceeds one
// - correction inserts or skips one count, at most once per 8192 cycles
// - magnitude gives number of adjusted periods out of each 128
// - sign positive adds counts slowing clock, negative skips counts speeding it
// - corrections shift periodic event spacing since events come from the prescaler
// - four storage registers cleared only by reset or tamper with clear bit set
// - storage pair enable n enables storage registers 2n and 2n+1
// - flags at 0x0c: overflow 15, tamper 14, alarm 8, periodic 7..0
// - overflow flag set on counter clock after counter overflow
// - tamper flag set once tamper detected
// - alarm flag set on counter clock after compare match
// - periodic flag n set on rising edge of prescaler bit n+2
// - writing one clears a flag, zero leaves it
// - interrupt request high when any flag set with its enable
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module rpc_top
  import rpc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // timing sources
  input  wire logic        osc_tick,
  input  wire logic        cnt_tick,
  input  wire logic        counter_overflow,
  input  wire logic        alarm_match,
  input  wire logic        tamper_detect,
  // outputs
  output logic      [7:0]  periodic_event,
  output logic             irq
);
  logic [CTRL_PSEL_W-1:0] counter_prescale_select;
  logic                   tamper_clears_storage;
  logic [1:0]             storage_pair_enable;
  logic [7:0]             periodic_event_output_enable;
  logic [7:0]             freq_correction_reg;
  logic [15:0]            calendar_interrupt_flags;
  logic [15:0]            irq_enable;
  logic [31:0]            general_purpose_storage [4];
  logic [PRESC_W-1:0]     prescaler;
  logic [PRESC_W-1:0]     next_prescaler;
  logic                   skip_pending;
  logic                   hold_pending;
  logic                   corr_apply;
  logic                   corr_active;
  logic [7:0]             per_rise;
  logic                   ovf_pend;
  logic                   alarm_pend;
  logic                   ack;
  logic                   wr_acc;
  logic [31:0]            wmask;
  logic [15:0]            flag_set;
  logic [15:0]            flag_clr;

  // byte-lane mask shared by the interrupt enable, flag and storage writes
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // one wait cycle per access: ack rises the cycle after the request appears
  assign wr_acc = avs_write && ack;
  assign wmask  = lane_mask(avs_byteenable);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else if (clk_en) begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  // waitrequest low only during the ack cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack);
    end
  end

  // control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_prescale_select      <= '0;
      tamper_clears_storage        <= 1'b0;
      storage_pair_enable          <= '0;
      periodic_event_output_enable <= '0;
      freq_correction_reg          <= '0;
    end else if (clk_en && wr_acc) begin
      case (avs_address)
        OFF_CTRL: begin
          if (avs_byteenable[0]) begin
            counter_prescale_select <= avs_writedata[CTRL_PSEL_LSB +: CTRL_PSEL_W];
            tamper_clears_storage   <= avs_writedata[CTRL_TAMPER_CLR];
          end
          if (avs_byteenable[1])
            storage_pair_enable <= avs_writedata[CTRL_PAIR_EN_LSB +: 2];
        end
        OFF_EVENT_CTRL: if (avs_byteenable[0]) periodic_event_output_enable <= avs_writedata[7:0];
        OFF_FREQ_CORR:  if (avs_byteenable[0]) freq_correction_reg <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // interrupt enable set/clear pair
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= '0;
    end else if (clk_en && wr_acc) begin
      if (avs_address == OFF_IEN_SET)
        irq_enable <= irq_enable | (avs_writedata[15:0] & wmask[15:0] & FLAG_MASK);
      else if (avs_address == OFF_IEN_CLR)
        irq_enable <= irq_enable & ~(avs_writedata[15:0] & wmask[15:0]);
    end
  end

  // storage survives everything but reset and tamper with clear enabled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) general_purpose_storage[i] <= '0;
    end else if (clk_en) begin
      if (tamper_detect && tamper_clears_storage) begin
        for (int i = 0; i < 4; i++) general_purpose_storage[i] <= '0;
      end else if (wr_acc && avs_address[7:4] == OFF_STORAGE[7:4] && storage_pair_enable[avs_address[3]]) begin
        general_purpose_storage[avs_address[3:2]] <=
          merge(general_purpose_storage[avs_address[3:2]], avs_writedata, wmask);
      end
    end
  end

  // correction runs only with a prescale select above one
  assign corr_active = counter_prescale_select > CTRL_PSEL_W'(1);

  rpc_corr u_corr (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .tick      (osc_tick),
    .active    (corr_active),
    .magnitude (freq_correction_reg[FC_VAL_W-1:0]),
    .apply     (corr_apply)
  );

  // free-running prescaler; positive sign holds one count, negative skips one count
  always_comb begin
    next_prescaler = prescaler;
    if (osc_tick) begin
      if (hold_pending)
        next_prescaler = prescaler; // inserted count lengthens the period
      else if (skip_pending)
        next_prescaler = prescaler + PRESC_W'(2); // skipped count shortens the period
      else
        next_prescaler = prescaler + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler    <= '0;
      hold_pending <= 1'b0;
      skip_pending <= 1'b0;
    end else if (clk_en) begin
      prescaler <= next_prescaler; // periodic taps see the corrected count
      if (osc_tick) begin
        hold_pending <= corr_apply && !freq_correction_reg[FC_SIGN];
        skip_pending <= corr_apply && freq_correction_reg[FC_SIGN];
      end
    end
  end

  // rising edge of taps 2..9; skip by two never jumps over bit 2 unseen since bit 2 flips every 4
  assign per_rise = ~prescaler[PER_LSB +: 8] & next_prescaler[PER_LSB +: 8];

  // periodic events are muted only when prescale select is zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_event <= '0;
    end else if (clk_en) begin
      periodic_event <= (counter_prescale_select != '0) ? (per_rise & periodic_event_output_enable) : '0;
    end
  end

  // overflow and alarm land on the next counter clock tick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_pend   <= 1'b0;
      alarm_pend <= 1'b0;
    end else if (clk_en) begin
      if (cnt_tick) begin
        ovf_pend   <= counter_overflow;
        alarm_pend <= alarm_match;
      end
    end
  end

  always_comb begin
    flag_set             = '0;
    flag_set[7:0]        = per_rise;
    flag_set[FLG_OVERFLOW] = cnt_tick && ovf_pend;
    flag_set[FLG_ALARM]    = cnt_tick && alarm_pend;
    flag_set[FLG_TAMPER] = tamper_detect;
  end

  assign flag_clr = (wr_acc && avs_address == OFF_FLAGS) ? (avs_writedata[15:0] & wmask[15:0]) : '0;

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      calendar_interrupt_flags <= FLAG_RESET;
    end else if (clk_en) begin
      calendar_interrupt_flags <= ((calendar_interrupt_flags & ~flag_clr) | flag_set) & FLAG_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(calendar_interrupt_flags & irq_enable);
    end
  end

  // read data registered on the answering cycle; unmapped reads zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (clk_en && (avs_read || avs_write) && !ack) begin
      case (avs_address)
        OFF_CTRL:     avs_readdata <= {22'h0, storage_pair_enable, 3'h0, tamper_clears_storage, counter_prescale_select};
        OFF_EVENT_CTRL: avs_readdata <= {24'h0, periodic_event_output_enable};
        OFF_FREQ_CORR:  avs_readdata <= {24'h0, freq_correction_reg};
        OFF_FLAGS:    avs_readdata <= {16'h0, calendar_interrupt_flags};
        OFF_IEN_CLR,
        OFF_IEN_SET:  avs_readdata <= {16'h0, irq_enable};
        OFF_PRESC:    avs_readdata <= {22'h0, prescaler};
        OFF_STATUS:   avs_readdata <= {30'h0, corr_active, irq};
        OFF_STORAGE, OFF_STORAGE + 8'h04, OFF_STORAGE + 8'h08, OFF_STORAGE + 8'h0c:
                      avs_readdata <= general_purpose_storage[avs_address[3:2]];
        default:      avs_readdata <= UNMAPPED_DATA;
      endcase
    end
  end

  // a flag cleared by software with no new event must be low next cycle
  a_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && flag_clr[0] && !flag_set[0] |=> !calendar_interrupt_flags[0])
    else $error("periodic flag 0 not cleared");
  // a periodic rise always sets its flag
  a_per_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && per_rise[3] |=> calendar_interrupt_flags[3])
    else $error("periodic flag 3 not set");
  // no events while prescale select is zero
  a_event_mute: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && counter_prescale_select == '0 |=> periodic_event == '0)
    else $error("periodic event with select zero");
  // enabled event follows a tap rise
  a_event_fire: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && counter_prescale_select != '0 && per_rise[0] && periodic_event_output_enable[0] |=> periodic_event[0])
    else $error("enabled event missing");
  // no correction with select at one or less
  a_corr_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    counter_prescale_select <= CTRL_PSEL_W'(1) |-> !corr_apply)
    else $error("correction while disabled");
  // positive correction holds the prescaler on the next tick
  a_corr_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && osc_tick && hold_pending |=> prescaler == $past(prescaler))
    else $error("inserted count not held");
  // irq follows enabled flags
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && |(calendar_interrupt_flags & irq_enable) |=> irq)
    else $error("irq missing");
  // tamper with clear bit wipes storage
  a_gp_wipe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && tamper_detect && tamper_clears_storage |=> general_purpose_storage[0] == '0 && calendar_interrupt_flags[FLG_TAMPER])
    else $error("tamper did not clear storage");
  // overflow sets flag on next counter tick
  a_ovf_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && cnt_tick && ovf_pend |=> calendar_interrupt_flags[FLG_OVERFLOW])
    else $error("overflow flag missing");
  // alarm sets its flag on the counter tick after the match was sampled
  a_alarm_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && cnt_tick && alarm_pend |=> calendar_interrupt_flags[FLG_ALARM])
    else $error("alarm flag missing");
  // tamper raises its flag even if software clears it in the same cycle
  a_tamper_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && tamper_detect |=> calendar_interrupt_flags[FLG_TAMPER])
    else $error("tamper flag missing");
  // negative correction jumps two counts on the next tick
  a_skip_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && osc_tick && skip_pending |=> prescaler == $past(prescaler) + PRESC_W'(2))
    else $error("skipped count not taken");
  // an ordinary tick advances the prescaler by exactly one
  a_presc_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && osc_tick && !hold_pending && !skip_pending |=> prescaler == $past(prescaler) + 1'b1)
    else $error("prescaler step wrong");
  // without a source tick the prescaler must not move
  a_presc_still: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !osc_tick |=> $stable(prescaler))
    else $error("prescaler moved without tick");
  // a single adjustment per period, never two in a row
  a_corr_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && corr_apply |=> !corr_apply)
    else $error("correction repeated");
  // storage keeps its contents when neither written nor wiped
  a_gp_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !wr_acc && !tamper_detect |=> $stable(general_purpose_storage[0]))
    else $error("storage changed on its own");
  // a write to a disabled pair is dropped
  a_gp_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && wr_acc && avs_address == OFF_STORAGE + 8'h08 && !storage_pair_enable[1] && !tamper_detect
    |=> $stable(general_purpose_storage[2]))
    else $error("disabled storage written");
  // reserved flag positions always read zero
  a_flag_unused: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (calendar_interrupt_flags & ~FLAG_MASK) == 16'h0000)
    else $error("reserved flag bit set");
  // writing zero to a set flag leaves it set
  a_flag_w0: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && wr_acc && avs_address == OFF_FLAGS && !avs_writedata[3] && calendar_interrupt_flags[3]
    |=> calendar_interrupt_flags[3])
    else $error("flag cleared by zero write");
  // irq drops once no enabled flag remains
  a_irq_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && (calendar_interrupt_flags & irq_enable) == 16'h0000 |=> !irq)
    else $error("irq without enabled flag");
  // a disabled output never pulses
  a_event_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> (periodic_event & ~$past(periodic_event_output_enable)) == 8'h00)
    else $error("disabled event pulsed");
endmodule // rpc_top

/* verification/rpc_tb.sv */
// rpc_tb: self-checking bench for rpc_top, one task per scenario
// assumes the avalon-mm slave answers through waitrequest and registered readdata
`timescale 1ns/1ps
module testbench;
  import rpc_pkg::*;
  // design signals
  logic        sys_clk, rst_n, avs_read, avs_write, osc_tick, cnt_tick;
  logic        counter_overflow, alarm_match, tamper_detect, avs_waitrequest, irq;
  logic [7:0]  avs_address, periodic_event;
  logic [31:0] avs_writedata, avs_readdata, rd;
  // bench bookkeeping
  int          err_total, n_compared, cycles;
  int          ev_cnt [8];

  rpc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .osc_tick(osc_tick),
    .cnt_tick(cnt_tick), .counter_overflow(counter_overflow), .alarm_match(alarm_match),
    .tamper_detect(tamper_detect), .periodic_event(periodic_event), .irq(irq));

  // 200 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // event pulses counted per output, a pulse stands exactly one cycle
  always @(posedge sys_clk) begin
    for (int i = 0; i < 8; i++) if (periodic_event[i] === 1'b1) ev_cnt[i]++;
  end

  // hang guard: the run needs about 33000 cycles, mostly the correction periods
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk); // keeps a following request out of this time step
  endtask

  // n source clock ticks, one every other cycle, then let pipelines drain
  task automatic ticks(input int n);
    repeat (n) begin
      osc_tick <= 1'b1;
      @(posedge sys_clk);
      osc_tick <= 1'b0;
      @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic pulse_cnt();
    cnt_tick <= 1'b1;
    @(posedge sys_clk);
    cnt_tick <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic pulse_tamper();
    tamper_detect <= 1'b1;
    @(posedge sys_clk);
    tamper_detect <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // n source clock ticks back to back, then let pipelines drain
  task automatic tick_run(input int n);
    osc_tick <= 1'b1;
    repeat (n) @(posedge sys_clk);
    osc_tick <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    check(avs_waitrequest, 1'b1);
    bus(1'b0, OFF_FLAGS, 0);
    check(rd, FLAG_RESET);
    bus(1'b0, 8'h3c, 0);
    check(rd, UNMAPPED_DATA);
    $display("test reset done");
  endtask

  task automatic t_periodic();
    bus(1'b1, OFF_CTRL, 32'h0000_0001);
    bus(1'b1, OFF_EVENT_CTRL, 32'h0000_00ff);
    for (int i = 0; i < 8; i++) ev_cnt[i] = 0;
    ticks(64);
    // over 64 ticks output n, for n 0..3, fires 64 / 2^(n+3) times whatever the phase
    for (int i = 0; i < 4; i++) check(ev_cnt[i], 32'd64 >> (i + 3));
    bus(1'b0, OFF_FLAGS, 0);
    check(rd[3:0], 4'hf);
    bus(1'b1, OFF_FLAGS, 32'h0000_0000);
    bus(1'b0, OFF_FLAGS, 0);
    check(rd[3:0], 4'hf);
    bus(1'b1, OFF_FLAGS, 32'h0000_00ff);
    bus(1'b0, OFF_FLAGS, 0);
    check(rd[7:0], 8'h00);
    $display("test periodic done");
  endtask

  task automatic t_select_zero();
    bus(1'b1, OFF_CTRL, 32'h0000_0000);
    for (int i = 0; i < 8; i++) ev_cnt[i] = 0;
    ticks(64);
    for (int i = 0; i < 8; i++) check(ev_cnt[i], 0);
    $display("test select zero done");
  endtask

  task automatic t_flags();
    bus(1'b1, OFF_IEN_SET, 32'h0000_c100);
    counter_overflow <= 1'b1;
    pulse_cnt();
    counter_overflow <= 1'b0;
    pulse_cnt();
    bus(1'b0, OFF_FLAGS, 0);
    check(rd[15], 1'b1);
    check(rd[8], 1'b0);
    alarm_match <= 1'b1;
    pulse_cnt();
    alarm_match <= 1'b0;
    pulse_cnt();
    pulse_tamper();
    bus(1'b0, OFF_FLAGS, 0);
    check(rd[8], 1'b1);
    check(rd[14], 1'b1);
    check(irq, 1'b1);
    bus(1'b1, OFF_IEN_CLR, 32'h0000_c1ff);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'b0);
    bus(1'b1, OFF_FLAGS, 32'h0000_c100);
    bus(1'b0, OFF_FLAGS, 0);
    check(rd[15:8], 8'h00);
    $display("test flags done");
  endtask

  task automatic t_storage();
    bus(1'b1, OFF_CTRL, 32'h0000_0100);
    bus(1'b1, OFF_STORAGE, 32'ha5a5_5a5a);
    bus(1'b1, OFF_STORAGE + 8'h08, 32'h0000_1234);
    bus(1'b0, OFF_STORAGE, 0);
    check(rd, 32'ha5a5_5a5a);
    bus(1'b0, OFF_STORAGE + 8'h08, 0);
    check(rd, 32'h0000_0000);
    pulse_tamper();
    bus(1'b0, OFF_STORAGE, 0);
    check(rd, 32'ha5a5_5a5a);
    bus(1'b1, OFF_CTRL, 32'h0000_0110);
    pulse_tamper();
    bus(1'b0, OFF_STORAGE, 0);
    check(rd, 32'h0000_0000);
    $display("test storage done");
  endtask

  // mid-run reset zeroes prescaler and period counter so the adjustment ticks are known
  task automatic t_correction();
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check(avs_waitrequest, 1'b1);
    check(avs_readdata, 32'h0000_0000);
    bus(1'b1, OFF_CTRL, 32'h0000_0002);
    bus(1'b1, OFF_EVENT_CTRL, 32'h0000_0001);
    bus(1'b1, OFF_FREQ_CORR, 32'h0000_007f);
    bus(1'b0, OFF_STATUS, 0);
    check(rd[1], 1'b1);
    for (int i = 0; i < 8; i++) ev_cnt[i] = 0;
    // 127 of 128: first carry ends the second period, the hold lands on the next tick
    tick_run(2 * CORR_PERIOD + 4);
    bus(1'b0, OFF_PRESC, 0);
    check(rd, 32'h0000_0003);
    // the held count pushes the last tap rise out of the window
    check(ev_cnt[0], 2 * CORR_PERIOD / 8);
    // negative sign: the third period end skips a count
    bus(1'b1, OFF_FREQ_CORR, 32'h0000_00ff);
    tick_run(CORR_PERIOD);
    bus(1'b0, OFF_PRESC, 0);
    check(rd, 32'h0000_0004);
    // select one: the fourth period end would carry but must not adjust
    bus(1'b1, OFF_CTRL, 32'h0000_0001);
    bus(1'b0, OFF_STATUS, 0);
    check(rd[1], 1'b0);
    tick_run(CORR_PERIOD);
    bus(1'b0, OFF_PRESC, 0);
    check(rd, 32'h0000_0004);
    $display("test correction done");
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, osc_tick, cnt_tick} = 4'h0;
    {counter_overflow, alarm_match, tamper_detect} = 3'h0;
    avs_address   = 8'h00;
    avs_writedata = 32'h0000_0000;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_periodic();
    t_select_zero();
    t_flags();
    t_storage();
    t_correction();
    print_verdict();
  end
endmodule // testbench
